// ===== hpsc_regs.svh
`ifndef HPSC_REGS_SVH
`define HPSC_REGS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define HPSC_ADDR_LINK_STS 12'h0d0
`define HPSC_ADDR_SLOT_CAP 12'h0d4
`define HPSC_ADDR_SLOT_CTL 12'h0d8

// ----------------------------------------
// slot capability fields
// ----------------------------------------
`define HPSC_CAP_ATTN_BTN 0
`define HPSC_CAP_PWR_CTLR 1
`define HPSC_CAP_ATTN_IND 3
`define HPSC_CAP_PWR_IND 4
`define HPSC_CAP_SURPRISE 5
`define HPSC_CAP_HP_CAPABLE 6
`define HPSC_CAP_PLV_LO 7
`define HPSC_CAP_PLV_HI 14
`define HPSC_CAP_PLS_LO 15
`define HPSC_CAP_PLS_HI 16
`define HPSC_CAP_PSN_LO 19
`define HPSC_CAP_PSN_HI 31
`define HPSC_CAP_RST 32'h0000_0000
`define HPSC_CAP_LOAD_MASK 32'hfff9_fffb
`define HPSC_CAP_RW_MASK 32'h0001_ff80

// ----------------------------------------
// slot control fields
// ----------------------------------------
`define HPSC_CTL_ABP_EN 0
`define HPSC_CTL_PFD_EN 1
`define HPSC_CTL_PDC_EN 3
`define HPSC_CTL_CC_EN 4
`define HPSC_CTL_HPI_EN 5
`define HPSC_CTL_AIC_LO 6
`define HPSC_CTL_AIC_HI 7
`define HPSC_CTL_PIC_LO 8
`define HPSC_CTL_PIC_HI 9
`define HPSC_CTL_PWR_OFF 10
`define HPSC_CTL_DLL_EN 12
`define HPSC_CTL_RST 16'h03c0
`define HPSC_CTL_WR_MASK 16'h17fb

// ----------------------------------------
// slot status and link status fields
// ----------------------------------------
`define HPSC_STS_ABP 16
`define HPSC_STS_PFD 17
`define HPSC_STS_PDC 19
`define HPSC_STS_CC 20
`define HPSC_STS_DLL 24
`define HPSC_LNK_ACTIVE 29
`define HPSC_LANE_STS_LO 2
`define HPSC_LANE_STS_HI 3

`endif

// ===== hpsc_pkg.sv
package hpsc_pkg;
	// ----------------------------------------
	// indicator encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		HPSC_IND_RSVD = 2'b00,
		HPSC_IND_ON = 2'b01,
		HPSC_IND_BLINK = 2'b10,
		HPSC_IND_OFF = 2'b11
	} hpsc_ind_t;
endpackage : hpsc_pkg

// ===== hpsc_sync.sv
`timescale 1ns/10ps
module hpsc_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic stage1_reg;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			stage1_reg <= d;
			q <= stage1_reg;
		end
	end
endmodule : hpsc_sync

// ===== hpsc_msg.sv
`timescale 1ns/10ps
module hpsc_msg (
	input wire logic clk,
	input wire logic rst,
	input wire logic plim_wr,
	input wire logic attn_wr,
	input wire logic pwr_wr,
	input wire hpsc_pkg::hpsc_ind_t attn_val,
	input wire hpsc_pkg::hpsc_ind_t pwr_val,
	output logic plim_msg,
	output logic attn_msg,
	output hpsc_pkg::hpsc_ind_t attn_code,
	output logic pwr_msg,
	output hpsc_pkg::hpsc_ind_t pwr_code
);
	// ----------------------------------------
	// message request pulses
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			plim_msg <= 1'b0;
			attn_msg <= 1'b0;
			pwr_msg <= 1'b0;
		end else begin
			plim_msg <= plim_wr;
			attn_msg <= attn_wr;
			pwr_msg <= pwr_wr;
		end
	end

	// codes stand until the next message of that kind
	always_ff @(posedge clk) begin
		if (rst) begin
			attn_code <= hpsc_pkg::HPSC_IND_OFF;
			pwr_code <= hpsc_pkg::HPSC_IND_OFF;
		end else begin
			if (attn_wr) begin
				attn_code <= attn_val;
			end
			if (pwr_wr) begin
				pwr_code <= pwr_val;
			end
		end
	end
endmodule : hpsc_msg

// ===== hpsc_slot_regs.sv
// Function
// - slot capability and control exist on downstream ports only.
// - read-only flags for button, power controller and both indicators.
// - read-only flag: card may be pulled without notice.
// - read-only flag: slot is hot-plug capable.
// - capability fields reset to zero, overridable by loaded defaults.
// - writable power limit value, bits 14:7; writes send power limit message.
// - writable power limit scale, bits 16:15; writes send power limit message.
// - read-only physical slot number, bits 31:19, loadable.
// - control bit 0 enables button press interrupt or wake.
// - control bit 1 enables power fault interrupt or wake.
// - control bit 3 enables presence change interrupt or wake.
// - control bit 4 enables command completed interrupt, never wake.
// - control bit 5 gates all hot-plug interrupts.
// - attention indicator bits 7:6, reset off; writes send message.
// - power indicator bits 9:8, reset off; writes send message.
// - control bit 10 requests slot power off when set.
// - control bit 12 enables link state change notification.
// - link state changed flag sets on change, cleared by writing one.
// - link active reads one while link layer is active.
`include "hpsc_regs.svh"
`timescale 1ns/10ps
module hpsc_slot_regs (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic DOWNSTREAM_STRAP,
	input wire logic LOAD_VALID,
	input wire logic [31:0] LOAD_CAP,
	input wire logic LINK_ACTIVE_STATE,
	input wire logic EV_ATTN_PRESSED,
	input wire logic EV_POWER_FAULT,
	input wire logic EV_PRESENCE_CHG,
	input wire logic EV_CMD_DONE,
	output logic HP_INT,
	output logic WAKE_REQ,
	output logic [1:0] ATTN_IND,
	output logic [1:0] PWR_IND,
	output logic SLOT_PWR_OFF,
	output logic MSG_PWR_LIMIT,
	output logic MSG_ATTN_IND,
	output hpsc_pkg::hpsc_ind_t MSG_ATTN_CODE,
	output logic MSG_PWR_IND,
	output hpsc_pkg::hpsc_ind_t MSG_PWR_CODE
);
	logic ds;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [31:0] cap_reg;
	logic [31:0] cap_next;
	logic [15:0] ctl_reg;
	logic [15:0] ctl_next;
	logic sts_abp_reg;
	logic sts_pfd_reg;
	logic sts_pdc_reg;
	logic sts_cc_reg;
	logic sts_dll_reg;
	logic link_prev_reg;
	logic hp_int_reg;
	logic wake_reg;
	logic [31:0] bmask;
	logic [31:0] rdata;
	logic [31:0] sts_word;
	logic setup;
	logic acc_wr;
	logic wr_cap;
	logic wr_ctl;
	logic wr_sts;
	logic plim_wr;
	logic attn_wr;
	logic pwr_wr;
	logic clr_lo;
	logic clr_hi;
	logic hit;

	// ----------------------------------------
	// port direction strap
	// ----------------------------------------
	// strap is a pin, so it is synchronised before use
	hpsc_sync u_strap (
		.clk(REF_CLK),
		.rst(RESET),
		.d(DOWNSTREAM_STRAP),
		.q(ds)
	);

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	generate
		for (genvar i = 0; i < 4; i++) begin : g_lane
			assign bmask[8*i+7:8*i] = {8{PSTRB[i]}};
		end
	endgenerate

	assign setup = PSEL && !PENABLE;
	assign acc_wr = PSEL && PENABLE && pready_reg && PWRITE;
	assign hit = (PADDR == `HPSC_ADDR_LINK_STS) ||
		(PADDR == `HPSC_ADDR_SLOT_CAP) ||
		(PADDR == `HPSC_ADDR_SLOT_CTL);
	// upstream: slot words read zero, writes dropped
	assign wr_cap = acc_wr && ds && (PADDR == `HPSC_ADDR_SLOT_CAP);
	assign wr_ctl = acc_wr && ds && (PADDR == `HPSC_ADDR_SLOT_CTL);
	assign wr_sts = wr_ctl;

	// one wait-free access phase: ready rises after setup
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			if (setup) begin
				pslverr_reg <= !hit;
			end
		end
	end

	always_comb begin
		sts_word = 32'h0000_0000;
		sts_word[`HPSC_STS_ABP] = sts_abp_reg;
		sts_word[`HPSC_STS_PFD] = sts_pfd_reg;
		sts_word[`HPSC_STS_PDC] = sts_pdc_reg;
		sts_word[`HPSC_STS_CC] = sts_cc_reg;
		sts_word[`HPSC_STS_DLL] = sts_dll_reg;
	end

	always_comb begin
		rdata = 32'h0000_0000;
		if (PADDR == `HPSC_ADDR_LINK_STS) begin
			rdata[`HPSC_LNK_ACTIVE] = LINK_ACTIVE_STATE;
		end else if (ds && PADDR == `HPSC_ADDR_SLOT_CAP) begin
			rdata = cap_reg;
		end else if (ds && PADDR == `HPSC_ADDR_SLOT_CTL) begin
			rdata = sts_word | {16'h0000, ctl_reg};
		end
	end

	// read data stands until the next read setup cycle
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup && !PWRITE) begin
			prdata_reg <= rdata;
		end
	end

	// ----------------------------------------
	// slot capability
	// ----------------------------------------
	always_comb begin
		cap_next = cap_reg;
		if (LOAD_VALID && ds) begin
			cap_next = LOAD_CAP & `HPSC_CAP_LOAD_MASK;
		end
		if (wr_cap) begin
			cap_next = (cap_next & ~(bmask & `HPSC_CAP_RW_MASK)) |
				(PWDATA & bmask & `HPSC_CAP_RW_MASK);
		end
	end

	// flags 6:0 and slot number change only by loading
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			cap_reg <= `HPSC_CAP_RST;
		end else begin
			cap_reg <= cap_next;
		end
	end

	// any write reaching a limit byte sends the message
	assign plim_wr = wr_cap && (|(bmask & `HPSC_CAP_RW_MASK));

	// ----------------------------------------
	// slot control
	// ----------------------------------------
	always_comb begin
		ctl_next = ctl_reg;
		if (wr_ctl) begin
			ctl_next = (ctl_reg & ~(bmask[15:0] & `HPSC_CTL_WR_MASK)) |
				(PWDATA[15:0] & bmask[15:0] & `HPSC_CTL_WR_MASK);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctl_reg <= `HPSC_CTL_RST;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// reserved 00b is stored and sent as written
	assign attn_wr = wr_ctl && PSTRB[0];
	assign pwr_wr = wr_ctl && PSTRB[1];

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ATTN_IND <= hpsc_pkg::HPSC_IND_OFF;
			PWR_IND <= hpsc_pkg::HPSC_IND_OFF;
			SLOT_PWR_OFF <= 1'b0;
		end else begin
			ATTN_IND <= ctl_next[`HPSC_CTL_AIC_HI:`HPSC_CTL_AIC_LO];
			PWR_IND <= ctl_next[`HPSC_CTL_PIC_HI:`HPSC_CTL_PIC_LO];
			SLOT_PWR_OFF <= ctl_next[`HPSC_CTL_PWR_OFF];
		end
	end

	hpsc_msg u_msg (
		.clk(REF_CLK),
		.rst(RESET),
		.plim_wr(plim_wr),
		.attn_wr(attn_wr),
		.pwr_wr(pwr_wr),
		.attn_val(hpsc_pkg::hpsc_ind_t'(
			PWDATA[`HPSC_CTL_AIC_HI:`HPSC_CTL_AIC_LO])),
		.pwr_val(hpsc_pkg::hpsc_ind_t'(
			PWDATA[`HPSC_CTL_PIC_HI:`HPSC_CTL_PIC_LO])),
		.plim_msg(MSG_PWR_LIMIT),
		.attn_msg(MSG_ATTN_IND),
		.attn_code(MSG_ATTN_CODE),
		.pwr_msg(MSG_PWR_IND),
		.pwr_code(MSG_PWR_CODE)
	);

	// ----------------------------------------
	// slot status flags
	// ----------------------------------------
	assign clr_lo = wr_sts && PSTRB[`HPSC_LANE_STS_LO];
	assign clr_hi = wr_sts && PSTRB[`HPSC_LANE_STS_HI];

	// a new event beats a clear in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			sts_abp_reg <= 1'b0;
			sts_pfd_reg <= 1'b0;
			sts_pdc_reg <= 1'b0;
			sts_cc_reg <= 1'b0;
		end else begin
			sts_abp_reg <= (ds && EV_ATTN_PRESSED) ||
				(sts_abp_reg && !(clr_lo && PWDATA[`HPSC_STS_ABP]));
			sts_pfd_reg <= (ds && EV_POWER_FAULT) ||
				(sts_pfd_reg && !(clr_lo && PWDATA[`HPSC_STS_PFD]));
			sts_pdc_reg <= (ds && EV_PRESENCE_CHG) ||
				(sts_pdc_reg && !(clr_lo && PWDATA[`HPSC_STS_PDC]));
			sts_cc_reg <= (ds && EV_CMD_DONE) ||
				(sts_cc_reg && !(clr_lo && PWDATA[`HPSC_STS_CC]));
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			link_prev_reg <= 1'b0;
			sts_dll_reg <= 1'b0;
		end else begin
			link_prev_reg <= LINK_ACTIVE_STATE;
			sts_dll_reg <= (ds && LINK_ACTIVE_STATE != link_prev_reg) ||
				(sts_dll_reg && !(clr_hi && PWDATA[`HPSC_STS_DLL]));
		end
	end

	// ----------------------------------------
	// interrupt and wake
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			hp_int_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			hp_int_reg <= ctl_reg[`HPSC_CTL_HPI_EN] && (
				(sts_abp_reg && ctl_reg[`HPSC_CTL_ABP_EN]) ||
				(sts_pfd_reg && ctl_reg[`HPSC_CTL_PFD_EN]) ||
				(sts_pdc_reg && ctl_reg[`HPSC_CTL_PDC_EN]) ||
				(sts_cc_reg && ctl_reg[`HPSC_CTL_CC_EN]) ||
				(sts_dll_reg && ctl_reg[`HPSC_CTL_DLL_EN]));
			// command completion never wakes
			wake_reg <= ds && (
				(EV_ATTN_PRESSED && ctl_reg[`HPSC_CTL_ABP_EN]) ||
				(EV_POWER_FAULT && ctl_reg[`HPSC_CTL_PFD_EN]) ||
				(EV_PRESENCE_CHG && ctl_reg[`HPSC_CTL_PDC_EN]));
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign PREADY = pready_reg;
	assign PRDATA = prdata_reg;
	assign PSLVERR = pslverr_reg;
	assign HP_INT = hp_int_reg;
	assign WAKE_REQ = wake_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	sequence s_setup_rd(logic [11:0] a);
		PSEL && !PENABLE && !PWRITE && PADDR == a;
	endsequence

	sequence s_ctl_wr;
		acc_wr && ds && PADDR == `HPSC_ADDR_SLOT_CTL;
	endsequence

	property p_upstream_zero;
		(!ds and s_setup_rd(`HPSC_ADDR_SLOT_CAP)) |=>
			PRDATA == 32'h0000_0000;
	endproperty
	a_upstream_zero: assert property (p_upstream_zero)
		else $error("upstream slot capability read not zero");

	property p_cap_flags_ro;
		acc_wr && !LOAD_VALID |=>
			cap_reg[`HPSC_CAP_HP_CAPABLE:`HPSC_CAP_ATTN_BTN] ==
			$past(cap_reg[`HPSC_CAP_HP_CAPABLE:`HPSC_CAP_ATTN_BTN]);
	endproperty
	a_cap_flags_ro: assert property (p_cap_flags_ro)
		else $error("capability flag changed by software write");

	property p_load_psn;
		LOAD_VALID && ds |=> cap_reg[`HPSC_CAP_PSN_HI:`HPSC_CAP_PSN_LO] ==
			$past(LOAD_CAP[`HPSC_CAP_PSN_HI:`HPSC_CAP_PSN_LO]);
	endproperty
	a_load_psn: assert property (p_load_psn)
		else $error("slot number not taken from loaded default");

	property p_plim_msg;
		acc_wr && ds && PADDR == `HPSC_ADDR_SLOT_CAP && PSTRB[1] |=>
			MSG_PWR_LIMIT ##1 !MSG_PWR_LIMIT || plim_wr;
	endproperty
	a_plim_msg: assert property (p_plim_msg)
		else $error("power limit write sent no message");

	property p_attn_msg;
		(s_ctl_wr and PSTRB[0]) |=> MSG_ATTN_IND &&
			MSG_ATTN_CODE == $past(PWDATA[`HPSC_CTL_AIC_HI:`HPSC_CTL_AIC_LO]);
	endproperty
	a_attn_msg: assert property (p_attn_msg)
		else $error("attention indicator message missing or wrong");

	property p_pwr_msg;
		(s_ctl_wr and PSTRB[1]) |=> MSG_PWR_IND ##1
			PWR_IND == $past(PWDATA[`HPSC_CTL_PIC_HI:`HPSC_CTL_PIC_LO], 2);
	endproperty
	a_pwr_msg: assert property (p_pwr_msg)
		else $error("power indicator message or state wrong");

	property p_pwr_off;
		(s_ctl_wr and PSTRB[1]) |=>
			SLOT_PWR_OFF == $past(PWDATA[`HPSC_CTL_PWR_OFF]);
	endproperty
	a_pwr_off: assert property (p_pwr_off)
		else $error("slot power request does not follow control");

	property p_dll_set;
		// a clear right after the set may legally drop it
		ds && LINK_ACTIVE_STATE != link_prev_reg |=>
			sts_dll_reg ##1 (sts_dll_reg || $past(clr_hi));
	endproperty
	a_dll_set: assert property (p_dll_set)
		else $error("link state change flag not held");

	property p_link_read;
		s_setup_rd(`HPSC_ADDR_LINK_STS) |=>
			PREADY && PRDATA[`HPSC_LNK_ACTIVE] == $past(LINK_ACTIVE_STATE);
	endproperty
	a_link_read: assert property (p_link_read)
		else $error("link active readback wrong");

	property p_master_gate;
		!ctl_reg[`HPSC_CTL_HPI_EN] |=> !HP_INT;
	endproperty
	a_master_gate: assert property (p_master_gate)
		else $error("interrupt raised with master enable clear");

	property p_int_raise;
		ctl_reg[`HPSC_CTL_HPI_EN] && ctl_reg[`HPSC_CTL_CC_EN] && sts_cc_reg
			|=> HP_INT;
	endproperty
	a_int_raise: assert property (p_int_raise)
		else $error("enabled event did not raise interrupt");

	property p_no_cc_wake;
		EV_CMD_DONE && !EV_ATTN_PRESSED && !EV_POWER_FAULT &&
			!EV_PRESENCE_CHG |=> !WAKE_REQ;
	endproperty
	a_no_cc_wake: assert property (p_no_cc_wake)
		else $error("command completion caused wake");

	property p_wake_abp;
		ds && EV_ATTN_PRESSED && ctl_reg[`HPSC_CTL_ABP_EN] |=> WAKE_REQ;
	endproperty
	a_wake_abp: assert property (p_wake_abp)
		else $error("enabled button press gave no wake");

	property p_reset_ctl;
		@(posedge REF_CLK) disable iff (1'b0)
		RESET |=> ctl_reg == `HPSC_CTL_RST &&
			ATTN_IND == hpsc_pkg::HPSC_IND_OFF;
	endproperty
	a_reset_ctl: assert property (p_reset_ctl)
		else $error("control reset value wrong");
endmodule : hpsc_slot_regs

// ===== hpsc_slot_model.sv
`timescale 1ns/10ps
module hpsc_slot_model (
	input wire logic clk,
	input wire logic rst,
	output logic [3:0] ev,
	output logic link_active,
	input wire logic wake_req,
	input wire logic msg_plim,
	input wire logic msg_attn,
	input wire logic msg_pwr
);
	// ----------------------------------------
	// slot side events and message counters
	// ----------------------------------------
	int wake_cnt;
	int plim_cnt;
	int attn_cnt;
	int pwr_cnt;
	initial begin
		ev = 4'h0;
		link_active = 1'b0;
	end
	// pulses stand one cycle, so each edge counts at most one
	always @(posedge clk) begin
		wake_cnt <= wake_cnt + (wake_req === 1'b1 ? 1 : 0);
		plim_cnt <= plim_cnt + (msg_plim === 1'b1 ? 1 : 0);
		attn_cnt <= attn_cnt + (msg_attn === 1'b1 ? 1 : 0);
		pwr_cnt <= pwr_cnt + (msg_pwr === 1'b1 ? 1 : 0);
	end
	// one-cycle pulse: 0 button, 1 fault, 2 presence, 3 command done
	task automatic fire(input int k);
		@(posedge clk);
		ev <= 4'h1 << k;
		@(posedge clk);
		ev <= 4'h0;
	endtask : fire
	task automatic set_link(input logic v);
		@(posedge clk);
		link_active <= v;
	endtask : set_link
endmodule : hpsc_slot_model

// ===== tb_top.sv
`include "hpsc_regs.svh"
`timescale 1ns/10ps
module tb_top;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	localparam logic [11:0] cap_a = `HPSC_ADDR_SLOT_CAP;
	localparam logic [11:0] ctl_a = `HPSC_ADDR_SLOT_CTL;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic strap = 1'b1;
	logic load_valid = 1'b0;
	logic [31:0] load_cap = 32'h0000_0000;
	logic [3:0] ev;
	logic link;
	logic hp_int;
	logic wake;
	logic [1:0] attn_ind;
	logic [1:0] pwr_ind;
	logic pwr_off;
	logic m_plim;
	logic m_attn;
	logic m_pwr;
	hpsc_pkg::hpsc_ind_t attn_code;
	hpsc_pkg::hpsc_ind_t pwr_code;
	int error_cnt = 0;
	int comparisons = 0;
	logic [31:0] rd;
	logic err;
	int en[4] = '{0, 1, 3, 4};
	int st[4] = '{16, 17, 19, 20};
	always #2.5 clk = ~clk;

	hpsc_slot_regs hpsc_slot_regs_inst (.REF_CLK(clk), .RESET(rst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .DOWNSTREAM_STRAP(strap),
		.LOAD_VALID(load_valid), .LOAD_CAP(load_cap),
		.LINK_ACTIVE_STATE(link), .EV_ATTN_PRESSED(ev[0]),
		.EV_POWER_FAULT(ev[1]), .EV_PRESENCE_CHG(ev[2]),
		.EV_CMD_DONE(ev[3]), .HP_INT(hp_int), .WAKE_REQ(wake),
		.ATTN_IND(attn_ind), .PWR_IND(pwr_ind), .SLOT_PWR_OFF(pwr_off),
		.MSG_PWR_LIMIT(m_plim), .MSG_ATTN_IND(m_attn),
		.MSG_ATTN_CODE(attn_code), .MSG_PWR_IND(m_pwr),
		.MSG_PWR_CODE(pwr_code));
	hpsc_slot_model hpsc_slot_model_inst (.clk(clk), .rst(rst), .ev(ev),
		.link_active(link), .wake_req(wake), .msg_plim(m_plim),
		.msg_attn(m_attn), .msg_pwr(m_pwr));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// apb transfer; no fixed latency assumed, the wait is bounded
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", {31'h0, pready}, 32'h1);
	endtask : apb
	task automatic rdc(input string name, input logic [11:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(name, rd, exp);
	endtask : rdc
	task automatic do_reset(input logic s);
		@(posedge clk);
		rst <= 1'b1;
		strap <= s;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : do_reset
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int p;
		int q;
		logic [31:0] v;
		do_reset(1'b1);
		rdc("cap reset", cap_a, 32'h0000_0000);
		rdc("ctl reset", ctl_a, 32'h0000_03c0);
		chk("pwr off", {31'h0, pwr_off}, 32'h0);
		apb(1'b0, 12'h0e0, 32'h0000_0000, 4'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		@(posedge clk);
		load_valid <= 1'b1;
		load_cap <= 32'hffff_ffff;
		@(posedge clk);
		load_valid <= 1'b0;
		rdc("cap load", cap_a, 32'hfff9_fffb);
		p = hpsc_slot_model_inst.plim_cnt;
		apb(1'b1, cap_a, 32'h0000_0000, 4'hf);
		rdc("cap ro kept", cap_a, 32'hfff8_007b);
		apb(1'b1, cap_a, 32'h0000_0080, 4'h1);
		apb(1'b1, cap_a, 32'h0001_0000, 4'h4);
		rdc("cap limit", cap_a, 32'hfff9_00fb);
		chk("plim msgs", hpsc_slot_model_inst.plim_cnt - p, 3);
		// indicator codes, every encoding, power bit both ways
		for (int i = 0; i < 4; i++) begin
			v = {21'h0, i[0], 2'(3 - i), 2'(i), 6'h00};
			p = hpsc_slot_model_inst.attn_cnt;
			q = hpsc_slot_model_inst.pwr_cnt;
			apb(1'b1, ctl_a, v, 4'h3);
			rdc("ctl ind", ctl_a, v);
			chk("attn ind", {30'h0, attn_ind}, 32'(i));
			chk("attn code", {30'h0, attn_code}, 32'(i));
			chk("pwr ind", {30'h0, pwr_ind}, 32'(3 - i));
			chk("pwr code", {30'h0, pwr_code}, 32'(3 - i));
			chk("pwr off", {31'h0, pwr_off}, 32'(i[0]));
			chk("attn msg", hpsc_slot_model_inst.attn_cnt - p, 1);
			chk("pwr msg", hpsc_slot_model_inst.pwr_cnt - q, 1);
		end
		apb(1'b1, ctl_a, 32'h0000_ffff, 4'h3);
		rdc("ctl mask", ctl_a, 32'h0000_17fb);
		// each event alone, then with the master gate off
		for (int k = 0; k < 4; k++) begin
			v = 32'h0000_03e0 | (32'h1 << en[k]);
			apb(1'b1, ctl_a, v, 4'h3);
			p = hpsc_slot_model_inst.wake_cnt;
			hpsc_slot_model_inst.fire(k);
			repeat (3) @(posedge clk);
			chk("hp int", {31'h0, hp_int}, 32'h1);
			q = hpsc_slot_model_inst.wake_cnt - p;
			chk("wake", 32'(q), (k < 3) ? 32'h1 : 32'h0);
			rdc("event flag", ctl_a, v | (32'h1 << st[k]));
			apb(1'b1, ctl_a, 32'h1 << st[k], 4'h4);
			repeat (2) @(posedge clk);
			chk("hp int clr", {31'h0, hp_int}, 32'h0);
			apb(1'b1, ctl_a, v & ~32'h0000_0020, 4'h3);
			hpsc_slot_model_inst.fire(k);
			repeat (3) @(posedge clk);
			chk("hp int gated", {31'h0, hp_int}, 32'h0);
			apb(1'b1, ctl_a, 32'h1 << st[k], 4'h4);
		end
		apb(1'b1, ctl_a, 32'h0000_13e0, 4'h3);
		hpsc_slot_model_inst.set_link(1'b1);
		repeat (3) @(posedge clk);
		rdc("link up", 12'h0d0, 32'h2000_0000);
		chk("hp int link", {31'h0, hp_int}, 32'h1);
		rdc("link flag", ctl_a, 32'h0100_13e0);
		apb(1'b1, ctl_a, 32'h0100_0000, 4'h8);
		rdc("link flag clr", ctl_a, 32'h0000_13e0);
		hpsc_slot_model_inst.set_link(1'b0);
		repeat (3) @(posedge clk);
		rdc("link down", 12'h0d0, 32'h0000_0000);
		rdc("link flag 2", ctl_a, 32'h0100_13e0);
		// upstream port: slot registers absent, writes ignored
		do_reset(1'b0);
		apb(1'b1, ctl_a, 32'h0000_0400, 4'h3);
		chk("up err", {31'h0, err}, 32'h0);
		rdc("up ctl", ctl_a, 32'h0000_0000);
		rdc("up cap", cap_a, 32'h0000_0000);
		chk("up pwr off", {31'h0, pwr_off}, 32'h0);
		results();
	end
	// whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		results();
	end
endmodule : tb_top
